// ### verilog/etc_map.vh
/*
 * register map, field positions, reset values and source codes of the
 * edge timing control block.
 * assumes a 32-bit apb with word-aligned registers; data sits in bits 15..0.
 */
`ifndef ETC_MAP_VH
`define ETC_MAP_VH

// ==========================================================================
// register byte offsets
`define ETC_OFF_CONTROL_ONE   12'h000
`define ETC_OFF_CONTROL_TWO   12'h004
`define ETC_OFF_IRQ_STATUS    12'h008
`define ETC_OFF_IRQ_MASK      12'h00c

// ==========================================================================
// measure_control_one fields
`define ETC_BIT_UNIT_ENABLE   15
`define ETC_BIT_IDLE_STOP     13
`define ETC_BIT_DELAY_GEN     12
`define ETC_BIT_EDGE_GATE     11
`define ETC_BIT_EDGE_ORDER    10
`define ETC_BIT_SRC_GROUND    9
`define ETC_BIT_TRIG_ENABLE   8
`define ETC_CONTROL_ONE_MASK  16'hbf00
`define ETC_CONTROL_ONE_RESET 16'h0000

// ==========================================================================
// measure_control_two fields
`define ETC_BIT_FIRST_SAMPLING   15
`define ETC_BIT_FIRST_POLARITY   14
`define ETC_FLD_FIRST_SEL_HI     13
`define ETC_FLD_FIRST_SEL_LO     10
`define ETC_BIT_SECOND_FLAG      9
`define ETC_BIT_FIRST_FLAG       8
`define ETC_BIT_SECOND_SAMPLING  7
`define ETC_BIT_SECOND_POLARITY  6
`define ETC_FLD_SECOND_SEL_HI    5
`define ETC_FLD_SECOND_SEL_LO    2
`define ETC_CONTROL_TWO_RESET    16'h0000

// ==========================================================================
// interrupt status and mask fields
`define ETC_IRQ_FIRST_EDGE    0
`define ETC_IRQ_SECOND_EDGE   1
`define ETC_IRQ_ORDER_BLOCK   2
`define ETC_IRQ_WIDTH         3
`define ETC_IRQ_RESET         3'h0

// ==========================================================================
// edge source select codes
`define ETC_SEL_CODE_3        4'h3
`define ETC_SEL_CODE_2        4'h2
`define ETC_SEL_CODE_1        4'h1
`define ETC_SEL_CODE_0        4'h0

`endif

// ### verilog/etc_edge_channel.v
/*
 * one edge channel: picks one of four sources, applies polarity and
 * edge or level response, and reports a hit.
 * assumes all four sources are already on the clk domain.
 */
module etc_edge_channel (
   // clock and reset
   input  wire       clk,
   input  wire       rst_n,
   // sources, index equals select code
   input  wire [3:0] sources,
   // configuration
   input  wire [3:0] sourceSel,
   input  wire       sampling,
   input  wire       polarity,
   // result
   output wire       hit
);

   // ==========================================================================
   // source selection
   reg  srcLevel;
   reg  srcPrev_q;
   wire riseSeen;
   wire fallSeen;

   // reserved codes 01xx and 1xxx select nothing
   always @* begin
      if (sourceSel[3:2] != 2'h0) begin
         srcLevel = 1'b0;
      end else begin
         srcLevel = sources[sourceSel[1:0]];
      end
   end

   // previous level for edge detection
   always @(posedge clk) begin
      if (!rst_n) begin
         srcPrev_q <= 1'b0;
      end else begin
         srcPrev_q <= srcLevel;
      end
   end

   assign riseSeen = srcLevel & ~srcPrev_q;
   assign fallSeen = ~srcLevel & srcPrev_q;

   // ==========================================================================
   // response
   // edge or level
   assign hit = sampling ? (polarity ? riseSeen : fallSeen)
                         : (srcLevel == polarity);

endmodule

// ### verilog/etc_edge_timing_control.v
/*
 * edge timing control: apb register file, two edge channels, edge gating
 * and ordering, current source, ground, delay and trigger controls,
 * sticky interrupt status with mask.
 * assumes edge pins are asynchronous; compare, timer, comparator, capture
 * and idle indications come from logic on clk.
 */
// Overview of operation
// - unit enable bit 15 switches the measurement unit on or off, except the ground bit 9 output
// - idle stop bit 13 halts the unit while processor idles
// - delay generation bit 12 enables edge delay generation
// - edge order bit 10 ignores second edge before first one
// - ground bit 9 grounds the current source output while set
// - trigger enable bit 8 lets the trigger output drive
// - bit 14 and bits 7..0 read zero whatever is written
// - four selectable trigger sources feed each edge channel
// - each channel has its own polarity setting
// - edge flags bits 8 and 9 set on edges, software writable
// - sampling bit picks edge response or level response
// - polarity bit one means positive, zero negative response
// - source codes 3,2,1,0 pick pins, compare, timer (second channel: pins, comparator, capture); others reserved
`include "etc_map.vh"

module etc_edge_timing_control #(
   parameter ADDR_WIDTH = 12
) (
   // clock and reset
   input  wire                  clk,
   input  wire                  rst_n,
   // apb slave
   input  wire                  psel,
   input  wire                  penable,
   input  wire                  pwrite,
   input  wire [ADDR_WIDTH-1:0] paddr,
   input  wire [31:0]           pwdata,
   output reg  [31:0]           prdata,
   output reg                   pready,
   output reg                   pslverr,
   // edge pins, asynchronous
   input  wire                  edgeInputPinOne,
   input  wire                  edgeInputPinTwo,
   // on-chip edge sources
   input  wire                  outputCompareUnit,
   input  wire                  timerEvent,
   input  wire                  comparatorEvent,
   input  wire                  inputCaptureEvent,
   // processor power state
   input  wire                  idleMode,
   // analog and trigger controls
   output reg                   currentSourceOn,
   output reg                   currentSourceGround,
   output reg                   delayGenerationOn,
   output reg                   triggerOut,
   // interrupt
   output reg                   irq
);

   // ==========================================================================
   // declarations
   reg  [15:0]               controlOne_q;
   reg  [15:0]               controlOne_d;
   reg  [15:0]               controlTwo_q;
   reg  [15:0]               controlTwo_d;
   reg  [`ETC_IRQ_WIDTH-1:0] irqStatus_q;
   reg  [`ETC_IRQ_WIDTH-1:0] irqStatus_d;
   reg  [`ETC_IRQ_WIDTH-1:0] irqMask_q;
   reg  [`ETC_IRQ_WIDTH-1:0] irqMask_d;
   reg  [31:0]               readData;
   reg                       addrHit;
   reg                       pinOneMeta_q;
   reg                       pinOneSync_q;
   reg                       pinTwoMeta_q;
   reg                       pinTwoSync_q;
   reg                       firstFlag_d;
   reg                       secondFlag_d;
   wire                      setupPhase;
   wire                      accessDone;
   wire                      writeDone;
   wire                      writeOne;
   wire                      writeTwo;
   wire                      writeStatus;
   wire                      writeMask;
   wire                      unitEnable;
   wire                      idleStop;
   wire                      edgeGate;
   wire                      edgeOrder;
   wire                      trigEnable;
   wire                      unitActive;
   wire                      edgesOpen;
   wire                      firstFlag;
   wire                      secondFlag;
   wire                      firstHit;
   wire                      secondHit;
   wire                      firstEvent;
   wire                      secondEvent;
   wire                      orderBlocked;
   wire [3:0]                firstSources;
   wire [3:0]                secondSources;
   wire [`ETC_IRQ_WIDTH-1:0] irqEvents;

   // ==========================================================================
   // apb phase decode
   assign setupPhase = psel & ~penable;
   assign accessDone = psel & penable & pready;
   assign writeDone  = accessDone & pwrite & addrHit;

   // address decode of the current request
   always @* begin
      if (paddr == `ETC_OFF_CONTROL_ONE) begin
         addrHit = 1'b1;
      end else if (paddr == `ETC_OFF_CONTROL_TWO) begin
         addrHit = 1'b1;
      end else if (paddr == `ETC_OFF_IRQ_STATUS) begin
         addrHit = 1'b1;
      end else if (paddr == `ETC_OFF_IRQ_MASK) begin
         addrHit = 1'b1;
      end else begin
         addrHit = 1'b0;
      end
   end

   // per-register write strobes, taken at the completing edge
   assign writeOne    = writeDone & (paddr == `ETC_OFF_CONTROL_ONE);
   assign writeTwo    = writeDone & (paddr == `ETC_OFF_CONTROL_TWO);
   assign writeStatus = writeDone & (paddr == `ETC_OFF_IRQ_STATUS);
   assign writeMask   = writeDone & (paddr == `ETC_OFF_IRQ_MASK);

   // ==========================================================================
   // read mux
   always @* begin
      readData = 32'h0000_0000;
      if (paddr == `ETC_OFF_CONTROL_ONE) begin
         readData[15:0] = controlOne_q & `ETC_CONTROL_ONE_MASK;
      end else if (paddr == `ETC_OFF_CONTROL_TWO) begin
         readData[15:0] = {controlTwo_q[15:2], 2'h0};
      end else if (paddr == `ETC_OFF_IRQ_STATUS) begin
         readData[`ETC_IRQ_WIDTH-1:0] = irqStatus_q;
      end else if (paddr == `ETC_OFF_IRQ_MASK) begin
         readData[`ETC_IRQ_WIDTH-1:0] = irqMask_q;
      end else begin
         readData = 32'h0000_0000;
      end
   end

   // ready, data and error, all answered in the first access cycle
   always @(posedge clk) begin
      if (!rst_n) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready  <= setupPhase;
         pslverr <= setupPhase & ~addrHit;
         if (setupPhase & ~pwrite) begin
            prdata <= readData;
         end else begin
            prdata <= 32'h0000_0000;
         end
      end
   end

   // ==========================================================================
   // control field views
   assign unitEnable = controlOne_q[`ETC_BIT_UNIT_ENABLE];
   assign idleStop   = controlOne_q[`ETC_BIT_IDLE_STOP];
   assign edgeGate   = controlOne_q[`ETC_BIT_EDGE_GATE];
   assign edgeOrder  = controlOne_q[`ETC_BIT_EDGE_ORDER];
   assign trigEnable = controlOne_q[`ETC_BIT_TRIG_ENABLE];
   assign firstFlag  = controlTwo_q[`ETC_BIT_FIRST_FLAG];
   assign secondFlag = controlTwo_q[`ETC_BIT_SECOND_FLAG];

   assign unitActive = unitEnable & ~(idleStop & idleMode);

   assign edgesOpen = unitActive & edgeGate;

   // ==========================================================================
   // pin synchronisers
   always @(posedge clk) begin
      if (!rst_n) begin
         pinOneMeta_q <= 1'b0;
         pinOneSync_q <= 1'b0;
         pinTwoMeta_q <= 1'b0;
         pinTwoSync_q <= 1'b0;
      end else begin
         pinOneMeta_q <= edgeInputPinOne;
         pinOneSync_q <= pinOneMeta_q;
         pinTwoMeta_q <= edgeInputPinTwo;
         pinTwoSync_q <= pinTwoMeta_q;
      end
   end

   // ==========================================================================
   // edge channels
   // four sources each
   assign firstSources  = {pinOneSync_q, pinTwoSync_q, outputCompareUnit, timerEvent};
   assign secondSources = {pinTwoSync_q, pinOneSync_q, comparatorEvent, inputCaptureEvent};

   etc_edge_channel u_firstChannel (
      .clk       (clk),
      .rst_n     (rst_n),
      .sources   (firstSources),
      .sourceSel (controlTwo_q[`ETC_FLD_FIRST_SEL_HI:`ETC_FLD_FIRST_SEL_LO]),
      .sampling  (controlTwo_q[`ETC_BIT_FIRST_SAMPLING]),
      .polarity  (controlTwo_q[`ETC_BIT_FIRST_POLARITY]),
      .hit       (firstHit)
   );

   etc_edge_channel u_secondChannel (
      .clk       (clk),
      .rst_n     (rst_n),
      .sources   (secondSources),
      .sourceSel (controlTwo_q[`ETC_FLD_SECOND_SEL_HI:`ETC_FLD_SECOND_SEL_LO]),
      .sampling  (controlTwo_q[`ETC_BIT_SECOND_SAMPLING]),
      .polarity  (controlTwo_q[`ETC_BIT_SECOND_POLARITY]),
      .hit       (secondHit)
   );

   // ==========================================================================
   // gating and ordering of edge events
   assign firstEvent = edgesOpen & firstHit;

   assign orderBlocked = edgesOpen & secondHit & edgeOrder & ~firstFlag;
   assign secondEvent  = edgesOpen & secondHit & ~orderBlocked;

   // ==========================================================================
   // control register one
   always @* begin
      controlOne_d = controlOne_q;
      if (writeOne) begin
         controlOne_d = pwdata[15:0] & `ETC_CONTROL_ONE_MASK;
      end
   end

   // ==========================================================================
   // control register two with edge flags
   always @* begin
      controlTwo_d = controlTwo_q;
      firstFlag_d  = firstFlag;
      secondFlag_d = secondFlag;
      if (writeTwo) begin
         controlTwo_d = {pwdata[15:2], 2'h0};
         firstFlag_d  = pwdata[`ETC_BIT_FIRST_FLAG];
         secondFlag_d = pwdata[`ETC_BIT_SECOND_FLAG];
      end
      // edge sets flag, wins over write
      controlTwo_d[`ETC_BIT_FIRST_FLAG]  = firstFlag_d | firstEvent;
      controlTwo_d[`ETC_BIT_SECOND_FLAG] = secondFlag_d | secondEvent;
   end

   // ==========================================================================
   // interrupt status and mask
   assign irqEvents = {orderBlocked, secondEvent, firstEvent};

   // sticky bits, write one clears, a new event wins
   always @* begin
      irqStatus_d = irqStatus_q;
      irqMask_d   = irqMask_q;
      if (writeStatus) begin
         irqStatus_d = irqStatus_q & ~pwdata[`ETC_IRQ_WIDTH-1:0];
      end
      if (writeMask) begin
         irqMask_d = pwdata[`ETC_IRQ_WIDTH-1:0];
      end
      irqStatus_d = irqStatus_d | irqEvents;
   end

   // ==========================================================================
   // register state
   always @(posedge clk) begin
      if (!rst_n) begin
         controlOne_q <= `ETC_CONTROL_ONE_RESET;
         controlTwo_q <= `ETC_CONTROL_TWO_RESET;
         irqStatus_q  <= `ETC_IRQ_RESET;
         irqMask_q    <= `ETC_IRQ_RESET;
      end else begin
         controlOne_q <= controlOne_d;
         controlTwo_q <= controlTwo_d;
         irqStatus_q  <= irqStatus_d;
         irqMask_q    <= irqMask_d;
      end
   end

   // ==========================================================================
   // analog, delay and trigger outputs
   // ground and the delay bit read the next-state control word, so they move
   // at the completing write edge; delay also needs the registered unit enable
   always @(posedge clk) begin
      if (!rst_n) begin
         currentSourceOn     <= 1'b0;
         currentSourceGround <= 1'b0;
         delayGenerationOn   <= 1'b0;
         triggerOut          <= 1'b0;
         irq                 <= 1'b0;
      end else begin
         currentSourceOn <= edgesOpen & controlTwo_d[`ETC_BIT_FIRST_FLAG]
                            & ~controlTwo_d[`ETC_BIT_SECOND_FLAG];
         currentSourceGround <= controlOne_d[`ETC_BIT_SRC_GROUND];
         delayGenerationOn <= unitActive & controlOne_d[`ETC_BIT_DELAY_GEN];
         triggerOut <= trigEnable & secondEvent;
         // level interrupt from unmasked status
         irq <= |(irqStatus_d & irqMask_d);
      end
   end

endmodule

// ### tb/etc_edge_timing_control_sva.sv
/* port checker for the edge timing control block.
   assumes a bind into etc_edge_timing_control and one clock domain. */
module etc_edge_timing_control_sva #(
   parameter ADDR_WIDTH = 12
) (
   // clock and reset
   input logic                  clk,
   input logic                  rst_n,
   // apb
   input logic                  psel,
   input logic                  penable,
   input logic                  pwrite,
   input logic [ADDR_WIDTH-1:0] paddr,
   input logic [31:0]           pwdata,
   input logic [31:0]           prdata,
   input logic                  pready,
   input logic                  pslverr,
   // controls and interrupt
   input logic                  currentSourceOn,
   input logic                  currentSourceGround,
   input logic                  delayGenerationOn,
   input logic                  triggerOut,
   input logic                  irq
);
   timeunit 1ns;
   timeprecision 1ps;
   logic wrOne;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // completing write to control one
   assign wrOne = psel & penable & pready & pwrite & (paddr == 0);
   // ======================================================
   // bus answer
   property p_setup_ready; psel && !penable |=> pready; endproperty
   a_setup_ready: assert property (p_setup_ready) else $error("no ready after setup");
   property p_ready_pulse; pready |=> !pready; endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than a cycle");
   property p_slverr_decode;
      psel && !penable |=> pslverr == ($past(paddr) > 12'h00c || $past(paddr[1:0]) != 2'h0);
   endproperty
   a_slverr_decode: assert property (p_slverr_decode) else $error("wrong slave error");
   // ======================================================
   // control one and output behaviour
   property p_reserved_zero;
      psel && penable && pready && !pwrite && paddr == 0 |->
         {prdata[31:16], prdata[14], prdata[7:0]} == 25'h0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits read one");
   property p_reset_quiet;
      $past(!rst_n) |-> !pready && !irq && !currentSourceOn && !currentSourceGround &&
         !delayGenerationOn && !triggerOut;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("output high after reset");
   property p_ground_follow; wrOne |-> ##2 currentSourceGround == $past(pwdata[9], 2); endproperty
   a_ground_follow: assert property (p_ground_follow) else $error("ground not following");
   property p_delay_off; wrOne && !(pwdata[15] && pwdata[12]) |-> ##2 !delayGenerationOn; endproperty
   a_delay_off: assert property (p_delay_off) else $error("delay generation left on");
   property p_source_gate;
      wrOne && !(pwdata[15] && pwdata[11]) |-> ##2 !currentSourceOn && !triggerOut;
   endproperty
   a_source_gate: assert property (p_source_gate) else $error("source on while blocked");
   property p_trig_ends; triggerOut |-> !currentSourceOn; endproperty
   a_trig_ends: assert property (p_trig_ends) else $error("source on at second edge");
endmodule

bind etc_edge_timing_control etc_edge_timing_control_sva #(.ADDR_WIDTH(ADDR_WIDTH)) u_sva (
   .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .currentSourceOn(currentSourceOn), .currentSourceGround(currentSourceGround),
   .delayGenerationOn(delayGenerationOn), .triggerOut(triggerOut), .irq(irq));

// ### tb/etc_source_model.sv
/* edge sources outside the block: two pins and four on-chip events.
   assumes the bench presents the wanted levels; each source follows them
   one rising edge later, as logic on clk would. */
module etc_source_model (
   // clock
   input  logic       clk,
   // levels asked for by the bench, same order as srcLevel
   input  logic [5:0] srcWant,
   // pin one, pin two, compare, timer, comparator, capture
   output logic [5:0] srcLevel
);
   timeunit 1ns;
   timeprecision 1ps;
   // each source takes its wanted level at the rising edge
   always @(posedge clk) srcLevel <= srcWant;
endmodule

// ### tb/etc_edge_timing_control_tb.sv
/* self-checking bench for the edge timing control block.
   assumes the checker bind and the source model compile alongside. */
module etc_edge_timing_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rst_n, psel, penable, pwrite, idleMode;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic        pready, pslverr, currentSourceOn, currentSourceGround;
   logic        delayGenerationOn, triggerOut, irq;
   logic [5:0]  src, srcWant;
   int          fails, check_count, trigCount;
   // ======================================================
   // design and far side
   etc_edge_timing_control #(.ADDR_WIDTH(12)) uut (
      .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .edgeInputPinOne(src[0]), .edgeInputPinTwo(src[1]), .outputCompareUnit(src[2]),
      .timerEvent(src[3]), .comparatorEvent(src[4]), .inputCaptureEvent(src[5]),
      .idleMode(idleMode), .currentSourceOn(currentSourceOn),
      .currentSourceGround(currentSourceGround), .delayGenerationOn(delayGenerationOn),
      .triggerOut(triggerOut), .irq(irq));
   etc_source_model model (.clk(clk), .srcWant(srcWant), .srcLevel(src));
   // 50 ns clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // count trigger pulses mid-cycle
   always @(negedge clk) if (triggerOut === 1'b1) trigCount++;
   // ======================================================
   // helpers
   task chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic e);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // pready, data and error are taken at the same rising edge
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask
   task rd(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk({r[31:1], r[0] | e}, exp);
   endtask
   task step(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask
   // ask one source for a level at the next rising edge
   task set(input int i, input logic v);
      @(posedge clk);
      srcWant[i] <= v;
   endtask
   // rising then falling pulse, two cycles wide
   task pulse(input int i);
      set(i, 1'b1);
      @(posedge clk);
      set(i, 1'b0);
   endtask
   // ======================================================
   // scenarios
   task t_regs;
      rd(12'h000, 32'h0);
      rd(12'h004, 32'h0);
      rd(12'h008, 32'h0);
      // reserved sources first, so enabling the unit raises no level hits
      wr(12'h004, 32'hffff);
      rd(12'h004, 32'hfffc);
      // pins count as routed before delay generation is switched on
      wr(12'h000, 32'hffffffff);
      rd(12'h000, 32'hbf00);
      step(2);
      chk({currentSourceGround, delayGenerationOn}, 2'b11);
      rd(12'h010, 32'h1);
      wr(12'h000, 32'h0200);
      step(2);
      chk({currentSourceGround, delayGenerationOn}, 2'b10);
      $display("regs done");
   endtask
   task t_order;
      wr(12'h000, 32'h0);
      step(2);
      chk(currentSourceGround, 1'b0);
      // discharge before measuring, converter held sampling meanwhile
      wr(12'h000, 32'h0200);
      step(2);
      chk(currentSourceGround, 1'b1);
      wr(12'h000, 32'h0);
      wr(12'h004, 32'hc0c4);
      wr(12'h00c, 32'h7);
      rd(12'h00c, 32'h7);
      wr(12'h000, 32'h8d00);
      pulse(4);
      step(4);
      rd(12'h008, 32'h4);
      rd(12'h004, 32'hc0c4);
      chk(irq, 1'b1);
      pulse(3);
      step(4);
      chk(currentSourceOn, 1'b1);
      pulse(4);
      step(4);
      chk({currentSourceOn, trigCount[7:0]}, 9'h001);
      rd(12'h008, 32'h7);
      rd(12'h004, 32'hc3c4);
      wr(12'h008, 32'h7);
      rd(12'h008, 32'h0);
      step(2);
      chk(irq, 1'b0);
      wr(12'h004, 32'hc0c4);
      wr(12'h000, 32'h8c00);
      pulse(3);
      pulse(4);
      step(4);
      chk(trigCount, 1);
      $display("order done");
   endtask
   // second channel: level, high active, on the idle-low capture source
   task t_block;
      wr(12'h004, 32'hc040);
      wr(12'h000, 32'h8000);
      pulse(3);
      step(4);
      rd(12'h004, 32'hc040);
      wr(12'h000, 32'h0800);
      pulse(3);
      step(4);
      rd(12'h004, 32'hc040);
      idleMode <= 1'b1;
      wr(12'h000, 32'ha800);
      pulse(3);
      step(4);
      rd(12'h004, 32'hc040);
      wr(12'h000, 32'h8800);
      pulse(3);
      step(4);
      rd(12'h004, 32'hc140);
      idleMode <= 1'b0;
      $display("block done");
   endtask
   task t_sources;
      for (int c = 0; c < 4; c++) begin
         wr(12'h004, 32'hc040 | (c << 10));
         pulse(3 - c);
         step(6);
         rd(12'h004, 32'hc140 | (c << 10));
      end
      wr(12'h004, 32'h8c40);
      set(0, 1'b1);
      step(6);
      rd(12'h004, 32'h8c40);
      set(0, 1'b0);
      step(6);
      rd(12'h004, 32'h8d40);
      wr(12'h004, 32'h404c);
      set(1, 1'b1);
      step(6);
      rd(12'h004, 32'h424c);
      set(1, 1'b0);
      // let the synchronised level drain before the flag is cleared
      step(4);
      wr(12'h004, 32'h40c0);
      pulse(5);
      step(4);
      rd(12'h004, 32'h42c0);
      wr(12'h004, 32'hd040);
      pulse(3);
      step(4);
      rd(12'h004, 32'hd040);
      $display("sources done");
   endtask
   // ======================================================
   // verdict
   task stop_test;
      $display("checks=%0d mismatches=%0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // watchdog
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      stop_test;
   end
   // main sequence
   initial begin
      rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 12'h000; pwdata = 32'h0; idleMode = 1'b0;
      srcWant = 6'h00;
      fails = 0; check_count = 0; trigCount = 0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      t_regs;
      t_order;
      t_block;
      t_sources;
      stop_test;
   end
endmodule
